//--- core/aced_defines.svh
// Register offsets, field positions, reset values and timing counts
`ifndef ACED_DEFINES_SVH
`define ACED_DEFINES_SVH

// ---------------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------------
`define ACED_OFS_IRQ_FLAG      8'h23
`define ACED_OFS_IGNORE_CTRL   8'h25

// ---------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------
`define ACED_BIT_IRQ_STICKY    0
`define ACED_BIT_IGN_RATE      6
`define ACED_BIT_IGN_BITCLK    5
`define ACED_BIT_IGN_RATIO     4
`define ACED_BIT_IGN_HALT      3
`define ACED_BIT_IGN_MISSING   2
`define ACED_BIT_AUTOSET_DIS   1
`define ACED_BIT_IGN_PLL       0

// ---------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------
`define ACED_RST_IRQ_FLAG      8'h00
`define ACED_RST_IGNORE_CTRL   8'h00

// ---------------------------------------------------------------------
// Detector limits and timing
// ---------------------------------------------------------------------
`define ACED_BCLK_MIN          10'h020
`define ACED_BCLK_MAX          10'h100
`define ACED_CLK_PERIOD_NS     100
`define ACED_HALT_NS           2000
`define ACED_MISSING_NS        5000
`define ACED_HALT_CYC \
    ((`ACED_HALT_NS + `ACED_CLK_PERIOD_NS - 1) / `ACED_CLK_PERIOD_NS)
`define ACED_MISSING_CYC \
    ((`ACED_MISSING_NS + `ACED_CLK_PERIOD_NS - 1) / `ACED_CLK_PERIOD_NS)

`endif

//--- core/aced_pkg.sv
// Types shared by the clock error detector
package aced_pkg;

    // One flag per detector; also the layout of the fault mask
    typedef struct packed {
        logic rate;
        logic bitclk;
        logic ratio;
        logic halt;
        logic missing;
        logic pll_unlock;
    } aced_fault_s;

    // Divider selection handed to the clock tree
    typedef struct packed {
        logic [6:0] div;
        logic [2:0] rate_mode;
    } aced_divsel_s;

endpackage : aced_pkg

//--- core/aced_top.sv
// Audio clock error detection, ignore control and sticky interrupt flag
// ---------------------------------------------------------------------
// Overview of operation
// - Bit 0 of the flag register is sticky and mirrors the irq pin.
// - Reading the flag register clears both flag and irq pin.
// - A fault mask chooses which faults may raise the interrupt.
// - Ignore-rate bit 6 keeps sample-rate errors out of clock error.
// - Bit clocks per frame must be stable within 32 to 256.
// - Ignore-bitclk bit 5 keeps bit-clock errors out of clock error.
// - Only listed master ratios within margin pass; bit 4 ignores.
// - Master clock halt is detected; ignore-halt bit 3 masks it.
// - Frame and bit clocks count missing only when held low.
// - Missing clocks power the converter down unless bit 2 is set.
// - Autoset-disable bit 1: zero automatic dividers, one manual.
// - Ignore-PLL bit 0 keeps PLL unlock out of clock error.
// - PLL lock status always shows the true lock state.
// - After reset all ignore bits and autoset-disable are zero.
// - Manual divider and rate-mode fields are unused during autoset.
// ---------------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
`include "aced_defines.svh"

module aced_top #(
    parameter int RATE_MIN_CYC = 100,
    parameter int RATE_MAX_CYC = 320,
    parameter int RATIO_TOL    = 2
) (
    input  wire logic                  clock,
    input  wire logic                  rst,
    input  wire logic [7:0]            reg_addr,
    input  wire logic [7:0]            reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [7:0]            reg_rdata_q,
    input  wire logic                  frame_clk,
    input  wire logic                  bit_clk,
    input  wire logic                  master_clk,
    input  wire logic                  pll_locked,
    input  wire aced_pkg::aced_fault_s fault_mask_reg,
    input  wire aced_pkg::aced_divsel_s manual_sel,
    input  wire aced_pkg::aced_divsel_s auto_sel,
    output aced_pkg::aced_divsel_s     div_sel_q,
    output logic                       clock_error_q,
    output logic                       dac_powerdown_q,
    output logic                       pin_irq_q,
    output logic                       pll_lock_flag_q
);

    // -----------------------------------------------------------------
    // Pin synchronisers
    // -----------------------------------------------------------------
    logic [2:0] pin_raw;
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic [2:0] sync3_q;
    logic [2:0] pin_rise;

    assign pin_raw = {master_clk, bit_clk, frame_clk};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            always_ff @(posedge clock) begin
                if (rst) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                    sync3_q[gi] <= 1'b0;
                end else begin
                    sync1_q[gi] <= pin_raw[gi];
                    sync2_q[gi] <= sync1_q[gi];
                    sync3_q[gi] <= sync2_q[gi];
                end
            end
            assign pin_rise[gi] = sync2_q[gi] & ~sync3_q[gi];
        end
    endgenerate

    logic fr_rise;
    logic bk_rise;
    logic mk_rise;
    assign fr_rise = pin_rise[0];
    assign bk_rise = pin_rise[1];
    assign mk_rise = pin_rise[2];

    // -----------------------------------------------------------------
    // Registers
    // -----------------------------------------------------------------
    logic [7:0] ign_q;
    logic [6:0] irq_resv_q;
    logic       rd_irq;
    logic       wr_ign;
    logic       wr_irq;

    assign rd_irq = reg_rd && (reg_addr == `ACED_OFS_IRQ_FLAG);
    assign wr_irq = reg_wr && (reg_addr == `ACED_OFS_IRQ_FLAG);
    assign wr_ign = reg_wr && (reg_addr == `ACED_OFS_IGNORE_CTRL);

    always_ff @(posedge clock) begin
        if (rst) begin
            ign_q <= `ACED_RST_IGNORE_CTRL;
        end else if (wr_ign) begin
            ign_q <= reg_wdata;
        end
    end

    // Reserved bits keep what was written; the flag bit is read-only
    always_ff @(posedge clock) begin
        if (rst) begin
            irq_resv_q <= 7'h00;
        end else if (wr_irq) begin
            irq_resv_q <= reg_wdata[7:1];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            reg_rdata_q <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `ACED_OFS_IRQ_FLAG:    reg_rdata_q <= {irq_resv_q, pin_irq_q};
                `ACED_OFS_IGNORE_CTRL: reg_rdata_q <= ign_q;
                default:               reg_rdata_q <= 8'h00;
            endcase
        end
    end

    // -----------------------------------------------------------------
    // Per-frame measurements
    // -----------------------------------------------------------------
    logic [9:0]  bclk_cnt_q;
    logic [9:0]  bclk_prev_q;
    logic [9:0]  mclk_cnt_q;
    logic [15:0] per_cnt_q;
    logic        have_prev_q;
    logic        bitclk_bad_q;
    logic        rate_bad_q;
    logic        ratio_bad_q;
    logic        ratio_ok;

    // Counters saturate so a runaway clock reads as too fast, not wraps
    always_ff @(posedge clock) begin
        if (rst) begin
            bclk_cnt_q <= 10'h000;
            mclk_cnt_q <= 10'h000;
            per_cnt_q  <= 16'h0000;
        end else if (fr_rise) begin
            bclk_cnt_q <= {9'h000, bk_rise};
            mclk_cnt_q <= {9'h000, mk_rise};
            per_cnt_q  <= 16'h0001;
        end else begin
            if (bk_rise && bclk_cnt_q != 10'h3ff)
                bclk_cnt_q <= bclk_cnt_q + 10'h001;
            if (mk_rise && mclk_cnt_q != 10'h3ff)
                mclk_cnt_q <= mclk_cnt_q + 10'h001;
            if (per_cnt_q != 16'hffff)
                per_cnt_q <= per_cnt_q + 16'h0001;
        end
    end

    function automatic logic ratio_match(input logic [9:0] cnt);
        logic [9:0] r;
        logic       hit;
        hit = 1'b0;
        for (int k = 0; k < 4; k++) begin
            r = 10'(64 << k);
            if ((cnt >= r - 10'(RATIO_TOL)) && (cnt <= r + 10'(RATIO_TOL)))
                hit = 1'b1;
        end
        return hit;
    endfunction : ratio_match

    assign ratio_ok = ratio_match(mclk_cnt_q);

    always_ff @(posedge clock) begin
        if (rst) begin
            bclk_prev_q  <= 10'h000;
            have_prev_q  <= 1'b0;
            bitclk_bad_q <= 1'b0;
            rate_bad_q   <= 1'b0;
            ratio_bad_q  <= 1'b0;
        end else if (fr_rise) begin
            bclk_prev_q  <= bclk_cnt_q;
            have_prev_q  <= 1'b1;
            bitclk_bad_q <= have_prev_q &&
                            ((bclk_cnt_q < `ACED_BCLK_MIN) ||
                             (bclk_cnt_q > `ACED_BCLK_MAX) ||
                             (bclk_cnt_q != bclk_prev_q));
            rate_bad_q   <= have_prev_q &&
                            ((per_cnt_q < 16'(RATE_MIN_CYC)) ||
                             (per_cnt_q > 16'(RATE_MAX_CYC)));
            ratio_bad_q  <= have_prev_q && !ratio_ok;
        end
    end

    // -----------------------------------------------------------------
    // Halt and missing detectors
    // -----------------------------------------------------------------
    localparam logic [7:0] HALT_CYC = 8'(`ACED_HALT_CYC);
    localparam logic [7:0] MISS_CYC = 8'(`ACED_MISSING_CYC);

    logic [7:0] halt_cnt_q;
    logic [7:0] miss_cnt_q;
    logic       halt_q;
    logic       missing_q;

    always_ff @(posedge clock) begin
        if (rst) begin
            halt_cnt_q <= 8'h00;
            halt_q     <= 1'b0;
        end else if (mk_rise) begin
            halt_cnt_q <= 8'h00;
            halt_q     <= 1'b0;
        end else if (halt_cnt_q < HALT_CYC) begin
            halt_cnt_q <= halt_cnt_q + 8'h01;
        end else begin
            halt_q     <= 1'b1;
        end
    end

    // A clock parked high is static but not missing
    always_ff @(posedge clock) begin
        if (rst) begin
            miss_cnt_q <= 8'h00;
            missing_q  <= 1'b0;
        end else if (sync2_q[0] || sync2_q[1]) begin
            miss_cnt_q <= 8'h00;
            missing_q  <= 1'b0;
        end else if (miss_cnt_q < MISS_CYC) begin
            miss_cnt_q <= miss_cnt_q + 8'h01;
        end else begin
            missing_q  <= 1'b1;
        end
    end

    // -----------------------------------------------------------------
    // Clock error, power-down, PLL flag and divider selection
    // -----------------------------------------------------------------
    aced_pkg::aced_fault_s faults;
    aced_pkg::aced_fault_s honoured;

    assign faults = '{rate: rate_bad_q, bitclk: bitclk_bad_q,
                      ratio: ratio_bad_q, halt: halt_q,
                      missing: missing_q, pll_unlock: ~pll_locked};

    always_comb begin
        honoured            = faults;
        honoured.rate       = faults.rate &
                              ~ign_q[`ACED_BIT_IGN_RATE];
        honoured.bitclk     = faults.bitclk &
                              ~ign_q[`ACED_BIT_IGN_BITCLK];
        honoured.ratio      = faults.ratio &
                              ~ign_q[`ACED_BIT_IGN_RATIO];
        honoured.halt       = faults.halt &
                              ~ign_q[`ACED_BIT_IGN_HALT];
        honoured.missing    = faults.missing &
                              ~ign_q[`ACED_BIT_IGN_MISSING];
        honoured.pll_unlock = faults.pll_unlock &
                              ~ign_q[`ACED_BIT_IGN_PLL];
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            clock_error_q   <= 1'b0;
            dac_powerdown_q <= 1'b0;
            pll_lock_flag_q <= 1'b0;
        end else begin
            clock_error_q   <= honoured.rate | honoured.bitclk |
                               honoured.ratio | honoured.halt |
                               honoured.pll_unlock;
            dac_powerdown_q <= honoured.missing;
            pll_lock_flag_q <= pll_locked;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            div_sel_q <= '0;
        end else if (ign_q[`ACED_BIT_AUTOSET_DIS]) begin
            div_sel_q <= manual_sel;
        end else begin
            div_sel_q <= auto_sel;
        end
    end

    // -----------------------------------------------------------------
    // Sticky interrupt
    // -----------------------------------------------------------------
    logic irq_src;
    logic irq_src_q;
    logic irq_evt;

    assign irq_src = |(faults & fault_mask_reg);
    assign irq_evt = irq_src & ~irq_src_q;

    // A new event in the reading cycle wins over the clear
    always_ff @(posedge clock) begin
        if (rst) begin
            irq_src_q <= 1'b0;
            pin_irq_q <= 1'b0;
        end else begin
            irq_src_q <= irq_src;
            if (irq_evt)
                pin_irq_q <= 1'b1;
            else if (rd_irq)
                pin_irq_q <= 1'b0;
        end
    end

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_irq_read;
        rd_irq && !irq_evt;
    endsequence

    sequence s_parked_low;
        !sync2_q[0] && !sync2_q[1];
    endsequence

    chk_irq_set: assert property (irq_evt |=> pin_irq_q)
        else $error("irq event did not set the sticky flag");
    chk_irq_read_clear: assert property (
        s_irq_read |=> !pin_irq_q)
        else $error("reading the flag did not clear it");
    chk_irq_masked: assert property (
        $rose(pin_irq_q) |-> $past(|(faults & fault_mask_reg)))
        else $error("irq rose from a masked fault");
    chk_rate_ignore: assert property (
        (ign_q[`ACED_BIT_IGN_RATE] && faults.rate && !honoured.bitclk &&
         !honoured.ratio && !honoured.halt && !honoured.pll_unlock)
        |=> !clock_error_q)
        else $error("ignored rate fault gave clock error");
    chk_bitclk_range: assert property (
        (fr_rise && have_prev_q && (bclk_cnt_q < `ACED_BCLK_MIN ||
         bclk_cnt_q > `ACED_BCLK_MAX))
        |=> bitclk_bad_q ##1 (clock_error_q ||
        $past(ign_q[`ACED_BIT_IGN_BITCLK])))
        else $error("bit clock count out of range not reported");
    chk_ratio_ignore: assert property (
        (!ign_q[`ACED_BIT_IGN_RATIO] && ratio_bad_q) |=> clock_error_q)
        else $error("honoured ratio fault gave no clock error");
    chk_halt_timeout: assert property (
        (halt_cnt_q == HALT_CYC && !mk_rise) |=> halt_q)
        else $error("halt not flagged after timeout");
    chk_missing_low: assert property (
        (miss_cnt_q == MISS_CYC) ##0 s_parked_low |=> missing_q)
        else $error("clocks held low not flagged as missing");
    chk_missing_high: assert property (
        sync2_q[0] |=> !missing_q ##1 !dac_powerdown_q)
        else $error("clock high yet missing or powered down");
    chk_powerdown: assert property (
        (missing_q && !ign_q[`ACED_BIT_IGN_MISSING]) |=> dac_powerdown_q)
        else $error("missing clocks did not power down");
    chk_autoset_mux: assert property (
        !ign_q[`ACED_BIT_AUTOSET_DIS] |=> div_sel_q == $past(auto_sel))
        else $error("manual fields used during autoset");
    chk_pll_ignore: assert property (
        (!ign_q[`ACED_BIT_IGN_PLL] && !pll_locked) |=> clock_error_q)
        else $error("PLL unlock did not raise clock error");
    chk_pll_flag: assert property (pll_locked |=> pll_lock_flag_q)
        else $error("PLL lock flag wrong");
    chk_reset_ctrl: assert property (
        $fell(rst) |-> ign_q == 8'h00)
        else $error("ignore control not zero after reset");

endmodule : aced_top
`default_nettype wire

//--- dv/aced_audio_src.sv
// Behavioural audio serial source driving frame, bit and master clocks
`timescale 1ns/10ps
`default_nettype none

module aced_audio_src (
    input  wire logic       clock,
    input  wire logic       run,
    input  wire logic       park_high,
    input  wire logic [8:0] bits,
    input  wire logic [3:0] bit_half,
    input  wire logic [3:0] mclk_half,
    output logic            frame_clk,
    output logic            bit_clk,
    output logic            master_clk
);
    int bcnt = 0;
    int bidx = 0;
    int mcnt = 0;

    initial begin
        frame_clk  = 1'b0;
        bit_clk    = 1'b0;
        master_clk = 1'b0;
    end

    // Pins move on the falling edge, away from the sampling edge
    always @(negedge clock) begin
        if (!run) begin
            // A stopped source parks frame and bit lines; only low counts as missing
            frame_clk <= park_high;
            bit_clk   <= park_high;
            bcnt      <= 0;
            bidx      <= 0;
        end else if (bcnt >= int'(bit_half) - 1) begin
            bcnt    <= 0;
            bit_clk <= ~bit_clk;
            // Frame level changes with the falling bit clock, high half last
            if (bit_clk) begin
                bidx      <= (bidx >= int'(bits) - 1) ? 0 : bidx + 1;
                frame_clk <= (bidx >= int'(bits) / 2 - 1) &&
                             (bidx < int'(bits) - 1);
            end
        end else begin
            bcnt <= bcnt + 1;
        end
    end

    // A zero half period holds the master clock static
    always @(negedge clock) begin
        if (mclk_half == 4'h0) begin
            master_clk <= 1'b0;
        end else if (mcnt >= int'(mclk_half) - 1) begin
            mcnt       <= 0;
            master_clk <= ~master_clk;
        end else begin
            mcnt <= mcnt + 1;
        end
    end
endmodule : aced_audio_src

`default_nettype wire

//--- dv/tb.sv
// Self-checking testbench for the clock error detector
`timescale 1ns/10ps
`default_nettype none
`include "aced_defines.svh"

`define CHK(nm, exp, got) begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
        bad_count++; \
        $display("FAIL %s exp %h got %h", nm, exp, got); \
    end \
end

module tb;
    logic                  clock = 1'b0;
    logic                  rst = 1'b1;
    logic [7:0]            reg_addr = 8'h00;
    logic [7:0]            reg_wdata = 8'h00;
    logic                  reg_wr = 1'b0;
    logic                  reg_rd = 1'b0;
    logic [7:0]            reg_rdata_q;
    logic                  frame_clk;
    logic                  bit_clk;
    logic                  master_clk;
    logic                  pll_locked = 1'b1;
    aced_pkg::aced_fault_s fault_mask_reg = '0;
    aced_pkg::aced_divsel_s manual_sel = 10'h15a;
    aced_pkg::aced_divsel_s auto_sel = 10'h2a5;
    aced_pkg::aced_divsel_s div_sel_q;
    logic                  clock_error_q;
    logic                  dac_powerdown_q;
    logic                  pin_irq_q;
    logic                  pll_lock_flag_q;
    logic                  run = 1'b0;
    logic                  park_high = 1'b0;
    logic [8:0]            bits = 9'h040;
    logic [3:0]            bit_half = 4'h1;
    logic [3:0]            mclk_half = 4'h1;
    logic [7:0]            rd;
    int                    bad_count = 0;
    int                    total_checks = 0;

    aced_top i_dut (.clock(clock), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata_q(reg_rdata_q), .frame_clk(frame_clk), .bit_clk(bit_clk),
        .master_clk(master_clk), .pll_locked(pll_locked),
        .fault_mask_reg(fault_mask_reg), .manual_sel(manual_sel),
        .auto_sel(auto_sel), .div_sel_q(div_sel_q),
        .clock_error_q(clock_error_q), .dac_powerdown_q(dac_powerdown_q),
        .pin_irq_q(pin_irq_q), .pll_lock_flag_q(pll_lock_flag_q));

    aced_audio_src i_src (.clock(clock), .run(run), .park_high(park_high),
        .bits(bits), .bit_half(bit_half), .mclk_half(mclk_half),
        .frame_clk(frame_clk), .bit_clk(bit_clk), .master_clk(master_clk));

    initial begin
        forever #50 clock = ~clock;
    end

    // -----------------------------------------------------------------
    // Register and source helpers
    // -----------------------------------------------------------------
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge clock);
        reg_wr = 1'b0;
        repeat (3) @(negedge clock);
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a);
        @(negedge clock);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge clock);
        reg_rd = 1'b0;
        @(negedge clock);
        rd = reg_rdata_q;
    endtask : reg_read

    // Over nine frames of the longest source setting, so old counts wash out
    task automatic set_src(input logic [8:0] b, input logic [3:0] bh,
                           input logic [3:0] mh);
        bits      = b;
        bit_half  = bh;
        mclk_half = mh;
        repeat (1200) @(negedge clock);
    endtask : set_src

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict

    // -----------------------------------------------------------------
    // Scenarios
    // -----------------------------------------------------------------
    task automatic t_regs;
        reg_read(`ACED_OFS_IRQ_FLAG);
        `CHK("flag reset", `ACED_RST_IRQ_FLAG, rd)
        reg_read(`ACED_OFS_IGNORE_CTRL);
        `CHK("ctrl reset", `ACED_RST_IGNORE_CTRL, rd)
        `CHK("autoset sel", auto_sel, div_sel_q)
        reg_write(8'h24, 8'hff);
        reg_read(8'h24);
        `CHK("unmapped", 8'h00, rd)
        reg_write(`ACED_OFS_IRQ_FLAG, 8'hff);
        reg_read(`ACED_OFS_IRQ_FLAG);
        `CHK("flag ro bit", 8'hfe, rd)
        reg_write(`ACED_OFS_IGNORE_CTRL, 8'hff);
        reg_read(`ACED_OFS_IGNORE_CTRL);
        `CHK("ctrl rw", 8'hff, rd)
        reg_write(`ACED_OFS_IGNORE_CTRL, 8'h00);
    endtask : t_regs

    // Apply a faulty source, expect an error, then ignore it away
    task automatic t_fault(input string nm, input logic [8:0] b,
                           input logic [3:0] bh, input logic [3:0] mh,
                           input logic [7:0] base, input int bit_pos);
        reg_write(`ACED_OFS_IGNORE_CTRL, base);
        set_src(b, bh, mh);
        `CHK(nm, 1'b1, clock_error_q)
        reg_write(`ACED_OFS_IGNORE_CTRL, base | (8'h01 << bit_pos));
        `CHK(nm, 1'b0, clock_error_q)
        reg_write(`ACED_OFS_IGNORE_CTRL, 8'h00);
        set_src(9'h040, 4'h1, 4'h1);
        `CHK("clean again", 1'b0, clock_error_q)
    endtask : t_fault

    task automatic t_pll;
        pll_locked = 1'b0;
        repeat (4) @(negedge clock);
        `CHK("unlock err", 1'b1, clock_error_q)
        `CHK("lock flag", 1'b0, pll_lock_flag_q)
        reg_write(`ACED_OFS_IGNORE_CTRL, 8'h01 << `ACED_BIT_IGN_PLL);
        `CHK("unlock ign", 1'b0, clock_error_q)
        `CHK("lock flag ign", 1'b0, pll_lock_flag_q)
        pll_locked = 1'b1;
        repeat (4) @(negedge clock);
        `CHK("lock flag up", 1'b1, pll_lock_flag_q)
        reg_write(`ACED_OFS_IGNORE_CTRL, 8'h00);
    endtask : t_pll

    task automatic t_missing;
        run = 1'b0;
        park_high = 1'b1;
        repeat (100) @(negedge clock);
        `CHK("parked high", 1'b0, dac_powerdown_q)
        park_high = 1'b0;
        repeat (100) @(negedge clock);
        `CHK("missing pd", 1'b1, dac_powerdown_q)
        reg_write(`ACED_OFS_IGNORE_CTRL, 8'h01 << `ACED_BIT_IGN_MISSING);
        `CHK("missing ign", 1'b0, dac_powerdown_q)
        reg_write(`ACED_OFS_IGNORE_CTRL, 8'h00);
        run = 1'b1;
        set_src(9'h040, 4'h1, 4'h1);
    endtask : t_missing

    task automatic t_irq;
        fault_mask_reg.pll_unlock = 1'b1;
        reg_read(`ACED_OFS_IRQ_FLAG);
        pll_locked = 1'b0;
        repeat (4) @(negedge clock);
        `CHK("irq pin", 1'b1, pin_irq_q)
        reg_read(`ACED_OFS_IRQ_FLAG);
        `CHK("irq flag", 1'b1, rd[`ACED_BIT_IRQ_STICKY])
        `CHK("irq cleared", 1'b0, pin_irq_q)
        reg_read(`ACED_OFS_IRQ_FLAG);
        `CHK("flag cleared", 1'b0, rd[`ACED_BIT_IRQ_STICKY])
        pll_locked = 1'b1;
        fault_mask_reg = '0;
        repeat (4) @(negedge clock);
        pll_locked = 1'b0;
        repeat (4) @(negedge clock);
        `CHK("irq masked", 1'b0, pin_irq_q)
        pll_locked = 1'b1;
        repeat (4) @(negedge clock);
    endtask : t_irq

    // Software takes the dividers by hand for an odd clock setup
    task automatic t_manual;
        reg_write(`ACED_OFS_IGNORE_CTRL,
                  8'h01 << `ACED_BIT_AUTOSET_DIS);
        `CHK("manual sel", manual_sel, div_sel_q)
        // Autoset cannot serve this PLL mode, so dividers are set by hand
        manual_sel = 10'h0c3;
        repeat (2) @(negedge clock);
        `CHK("manual reprog", 10'h0c3, div_sel_q)
        reg_write(`ACED_OFS_IGNORE_CTRL, 8'h00);
        `CHK("auto sel", auto_sel, div_sel_q)
    endtask : t_manual

    initial begin
        repeat (100000) @(posedge clock);
        bad_count++;
        give_verdict();
    end

    initial begin
        repeat (20) @(negedge clock);
        rst = 1'b0;
        t_regs();
        run = 1'b1;
        set_src(9'h040, 4'h1, 4'h1);
        `CHK("good clocks", 1'b0, clock_error_q)
        t_fault("bitclk", 9'h010, 4'h4, 4'h1, 8'h00,
                `ACED_BIT_IGN_BITCLK);
        t_fault("ratio", 9'h040, 4'h1, 4'h2, 8'h00,
                `ACED_BIT_IGN_RATIO);
        t_fault("rate", 9'h020, 4'h1, 4'h1, 8'h10,
                `ACED_BIT_IGN_RATE);
        t_fault("halt", 9'h040, 4'h1, 4'h0, 8'h10,
                `ACED_BIT_IGN_HALT);
        t_pll();
        t_missing();
        t_irq();
        t_manual();
        give_verdict();
    end
endmodule : tb

`default_nettype wire
